// [txis_top.sv]
/*
  Transmit output stage: path switch, line state generator, symbol
  injection, serializer and line coding.
  Assumes an outside 4b/5b encoder, repeat filter and smoother feed
  filtered_pair_in, stable across each byte period.
*/
`timescale 1ns/10ps
`include "txis_map.svh"

module txis_top
  import txis_pkg::*;
#(
  parameter bit SINGLE_PORT = 1'b0,
  parameter int THRESH_W = 8
)
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire txis_byte_t req_first_in,
  input wire txis_byte_t req_second_in,
  input wire txis_byte_t receive_bus_in,
  input wire logic [5:0] path_config_reg_in,
  input wire logic [7:0] transmit_state_reg_in,
  input wire logic [7:0] injection_ctl_reg_in,
  input wire logic [7:0] mode_reg_in,
  input wire logic [THRESH_W-1:0] injection_threshold_in,
  input wire logic [4:0] injection_symbol_first_in,
  input wire logic [4:0] injection_symbol_second_in,
  input wire txis_code_pair_t filtered_pair_in,
  output txis_byte_t indicate_first_out,
  output txis_byte_t indicate_second_out,
  output txis_byte_t tx_path_out,
  output logic byte_strobe_out,
  output txis_code_pair_t tx_pair_out,
  output logic injecting_out,
  output logic pmd_tx_enable_out,
  output logic serial_out
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  txis_byte_t link_invalid_bus;
  txis_byte_t first_req_bus;
  txis_byte_t bus_sel [4];
  txis_byte_t ind_first_d;
  txis_byte_t ind_second_d;
  txis_byte_t tx_path_d;
  txis_byte_t ind_first_q;
  txis_byte_t ind_second_q;
  txis_byte_t tx_path_q;

  logic [3:0] bit_cnt_q;
  logic [3:0] bit_cnt_d;
  logic byte_tick;

  logic [2:0] transmit_mode_field;
  logic [1:0] injection_select;
  logic plain_coding_select;

  txis_code_pair_t gen_pair;
  txis_code_pair_t inj_pair;
  txis_code_pair_t out_pair;
  logic gen_override;
  logic master_phase_q;
  logic master_phase_d;
  logic jk_seen;

  txis_os_state_t os_state_q;
  txis_os_state_t os_state_d;
  logic [THRESH_W-1:0] os_cnt_q;
  logic [THRESH_W-1:0] os_cnt_d;
  logic [THRESH_W:0] per_cnt_q;
  logic [THRESH_W:0] per_cnt_d;
  logic [THRESH_W:0] per_next;
  logic inject;

  txis_code_pair_t tx_pair_q;
  txis_code_pair_t tx_pair_d;
  logic injecting_q;
  logic injecting_d;
  logic pmd_en_q;
  logic pmd_en_d;

  // ----------------------------------------------------------------
  // configuration switch
  // ----------------------------------------------------------------
  assign link_invalid_bus = `TXIS_LINK_INVALID;
  assign first_req_bus = SINGLE_PORT ? link_invalid_bus : req_first_in;

  always_comb
  begin
    bus_sel[`TXIS_BUS_FIRST_REQ] = first_req_bus;
    bus_sel[`TXIS_BUS_SECOND_REQ] = req_second_in;
    bus_sel[`TXIS_BUS_RECEIVE] = receive_bus_in;
    bus_sel[`TXIS_BUS_LINK_INVALID] = link_invalid_bus;
    ind_first_d = bus_sel[path_config_reg_in[`TXIS_CFG_IND_FIRST_LSB +: 2]];
    ind_second_d = bus_sel[path_config_reg_in[`TXIS_CFG_IND_SECOND_LSB +: 2]];
    tx_path_d = bus_sel[path_config_reg_in[`TXIS_CFG_TX_LSB +: 2]];
    if (SINGLE_PORT)
    begin
      ind_second_d = '0;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ind_first_q <= '0;
      ind_second_q <= '0;
      tx_path_q <= '0;
    end
    else
    begin
      ind_first_q <= ind_first_d;
      ind_second_q <= ind_second_d;
      tx_path_q <= tx_path_d;
    end
  end

  // ----------------------------------------------------------------
  // byte timer: ten bit times per byte
  // ----------------------------------------------------------------
  assign byte_tick = (bit_cnt_q == `TXIS_BIT_LAST);

  always_comb
  begin
    if (byte_tick)
    begin
      bit_cnt_d = `TXIS_BIT_ZERO;
    end
    else
    begin
      bit_cnt_d = bit_cnt_q + 4'h1;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      bit_cnt_q <= `TXIS_BIT_ZERO;
    end
    else
    begin
      bit_cnt_q <= bit_cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  assign transmit_mode_field = transmit_state_reg_in[`TXIS_TSR_TM_LSB +: 3];
  assign injection_select = injection_ctl_reg_in[`TXIS_TSR_IC_LSB +: 2];
  assign plain_coding_select = mode_reg_in[`TXIS_MODE_PLAIN_BIT];

  // ----------------------------------------------------------------
  // line state generator
  // ----------------------------------------------------------------
  always_comb
  begin
    gen_override = 1'b1;
    master_phase_d = master_phase_q;
    pmd_en_d = 1'b1;
    gen_pair = '{first: `TXIS_SYM_QUIET, second: `TXIS_SYM_QUIET};
    case (transmit_mode_field)
      `TXIS_TM_ACTIVE:
      begin
        gen_override = 1'b0;
      end
      `TXIS_TM_OFF:
      begin
        pmd_en_d = 1'b0;
      end
      `TXIS_TM_IDLE:
      begin
        gen_pair = '{first: `TXIS_SYM_IDLE, second: `TXIS_SYM_IDLE};
      end
      `TXIS_TM_MASTER:
      begin
        if (master_phase_q)
        begin
          gen_pair = '{first: `TXIS_SYM_QUIET, second: `TXIS_SYM_QUIET};
        end
        else
        begin
          gen_pair = '{first: `TXIS_SYM_HALT, second: `TXIS_SYM_HALT};
        end
        if (byte_tick)
        begin
          master_phase_d = ~master_phase_q;
        end
      end
      `TXIS_TM_QUIET, `TXIS_TM_RSVD:
      begin
        gen_pair = '{first: `TXIS_SYM_QUIET, second: `TXIS_SYM_QUIET};
      end
      `TXIS_TM_HALT:
      begin
        gen_pair = '{first: `TXIS_SYM_HALT, second: `TXIS_SYM_HALT};
      end
      default:
      begin
        gen_pair = '{first: `TXIS_SYM_QUIET, second: `TXIS_SYM_QUIET};
      end
    endcase
    if (transmit_mode_field != `TXIS_TM_MASTER)
    begin
      master_phase_d = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // injection control
  // ----------------------------------------------------------------
  assign jk_seen = (filtered_pair_in.first == `TXIS_SYM_J)
    && (filtered_pair_in.second == `TXIS_SYM_K);
  assign inj_pair = '{first: injection_symbol_first_in,
    second: injection_symbol_second_in};
  assign per_next = per_cnt_q + {{THRESH_W{1'b0}}, 1'b1};

  always_comb
  begin
    inject = 1'b0;
    os_state_d = os_state_q;
    os_cnt_d = os_cnt_q;
    per_cnt_d = per_cnt_q;
    case (injection_select)
      `TXIS_IC_NONE:
      begin
        os_state_d = TXIS_OS_IDLE;
        per_cnt_d = '0;
      end
      `TXIS_IC_ONESHOT:
      begin
        per_cnt_d = '0;
        if (byte_tick)
        begin
          if (jk_seen)
          begin
            if (injection_threshold_in == `TXIS_THRESH_ZERO)
            begin
              inject = 1'b1;
              os_state_d = TXIS_OS_DONE;
            end
            else
            begin
              os_state_d = TXIS_OS_COUNT;
              os_cnt_d = {{(THRESH_W-1){1'b0}}, 1'b1};
            end
          end
          else if (os_state_q == TXIS_OS_COUNT)
          begin
            if (os_cnt_q == injection_threshold_in)
            begin
              inject = 1'b1;
              os_state_d = TXIS_OS_DONE;
            end
            else
            begin
              os_cnt_d = os_cnt_q + {{(THRESH_W-1){1'b0}}, 1'b1};
            end
          end
        end
      end
      `TXIS_IC_PERIODIC:
      begin
        os_state_d = TXIS_OS_IDLE;
        if (byte_tick)
        begin
          if (per_next >= {1'b0, injection_threshold_in})
          begin
            inject = 1'b1;
            per_cnt_d = '0;
          end
          else
          begin
            per_cnt_d = per_next;
          end
        end
      end
      `TXIS_IC_CONT:
      begin
        os_state_d = TXIS_OS_IDLE;
        per_cnt_d = '0;
        inject = byte_tick;
      end
      default:
      begin
        os_state_d = TXIS_OS_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // output pair selection: injection, generator, stream
  // ----------------------------------------------------------------
  always_comb
  begin
    if (inject)
    begin
      out_pair = inj_pair;
    end
    else if (gen_override)
    begin
      out_pair = gen_pair;
    end
    else
    begin
      out_pair = filtered_pair_in;
    end
    tx_pair_d = byte_tick ? out_pair : tx_pair_q;
    injecting_d = byte_tick ? inject : injecting_q;
  end

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      master_phase_q <= 1'b0;
      os_state_q <= TXIS_OS_IDLE;
      os_cnt_q <= '0;
      per_cnt_q <= '0;
      tx_pair_q <= '0;
      injecting_q <= 1'b0;
      pmd_en_q <= 1'b0;
    end
    else
    begin
      master_phase_q <= master_phase_d;
      os_state_q <= os_state_d;
      os_cnt_q <= os_cnt_d;
      per_cnt_q <= per_cnt_d;
      tx_pair_q <= tx_pair_d;
      injecting_q <= injecting_d;
      pmd_en_q <= pmd_en_d;
    end
  end

  // ----------------------------------------------------------------
  // serializer
  // ----------------------------------------------------------------
  txis_shifter u_shifter (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .load_in(byte_tick),
    .pair_in(out_pair),
    .plain_coding_select_in(plain_coding_select),
    .serial_out(serial_out)
  );

  assign indicate_first_out = ind_first_q;
  assign indicate_second_out = ind_second_q;
  assign tx_path_out = tx_path_q;
  assign byte_strobe_out = byte_tick;
  assign tx_pair_out = tx_pair_q;
  assign injecting_out = injecting_q;
  assign pmd_tx_enable_out = pmd_en_q;

endmodule : txis_top

// [txis_map.svh]
/*
  Constants of the transmit line-state, injection and path switch block:
  mode codes, symbol codes, field positions and timing counts.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef TXIS_MAP_SVH
`define TXIS_MAP_SVH

// ----------------------------------------------------------------
// transmit mode codes
// ----------------------------------------------------------------
`define TXIS_TM_ACTIVE 3'h0
`define TXIS_TM_OFF 3'h1
`define TXIS_TM_IDLE 3'h2
`define TXIS_TM_MASTER 3'h3
`define TXIS_TM_QUIET 3'h4
`define TXIS_TM_RSVD 3'h5
`define TXIS_TM_HALT 3'h6

// ----------------------------------------------------------------
// injection select codes
// ----------------------------------------------------------------
`define TXIS_IC_NONE 2'h0
`define TXIS_IC_ONESHOT 2'h1
`define TXIS_IC_PERIODIC 2'h2
`define TXIS_IC_CONT 2'h3

// ----------------------------------------------------------------
// 5b line symbols
// ----------------------------------------------------------------
`define TXIS_SYM_IDLE 5'h1F
`define TXIS_SYM_HALT 5'h04
`define TXIS_SYM_QUIET 5'h00
`define TXIS_SYM_J 5'h18
`define TXIS_SYM_K 5'h11

// ----------------------------------------------------------------
// switch buses and fields
// ----------------------------------------------------------------
`define TXIS_LINK_INVALID 10'h13A
`define TXIS_BUS_FIRST_REQ 2'h0
`define TXIS_BUS_SECOND_REQ 2'h1
`define TXIS_BUS_RECEIVE 2'h2
`define TXIS_BUS_LINK_INVALID 2'h3
`define TXIS_CFG_IND_FIRST_LSB 0
`define TXIS_CFG_IND_SECOND_LSB 2
`define TXIS_CFG_TX_LSB 4
`define TXIS_MODE_PLAIN_BIT 6
`define TXIS_TSR_TM_LSB 0
`define TXIS_TSR_IC_LSB 0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define TXIS_BITS_PER_BYTE 10
`define TXIS_BIT_LAST 4'h9
`define TXIS_BIT_ZERO 4'h0
`define TXIS_THRESH_ZERO 8'h00

`endif

// [txis_pkg.sv]
/*
  Types of the transmit line-state, injection and path switch block.
  Assumes txis_map.svh is reachable by bare name.
*/
`include "txis_map.svh"

package txis_pkg;

  // ----------------------------------------------------------------
  // switch bus byte: parity, control flag, two symbols
  // ----------------------------------------------------------------
  typedef struct packed {
    logic parity;
    logic ctrl;
    logic [7:0] data;
  } txis_byte_t;

  // ----------------------------------------------------------------
  // encoded symbol pair, first symbol sent first
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [4:0] first;
    logic [4:0] second;
  } txis_code_pair_t;

  typedef enum logic [1:0] {
    TXIS_OS_IDLE,
    TXIS_OS_COUNT,
    TXIS_OS_DONE
  } txis_os_state_t;

endpackage : txis_pkg

// [txis_shifter.sv]
/*
  Serializer with optional NRZ to NRZI coding.
  Assumes load_in pulses once per byte period on the single block clock.
*/
`timescale 1ns/10ps

module txis_shifter
  import txis_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic load_in,
  input wire txis_code_pair_t pair_in,
  input wire logic plain_coding_select_in,
  output logic serial_out
);

  logic [9:0] shift_q;
  logic [9:0] shift_d;
  logic line_q;
  logic line_d;
  logic nrz_bit;

  // ----------------------------------------------------------------
  // load on byte boundary, shift one bit per clock
  // ----------------------------------------------------------------
  always_comb
  begin
    if (load_in)
    begin
      shift_d = pair_in;
    end
    else
    begin
      shift_d = {shift_q[8:0], 1'b0};
    end
    nrz_bit = shift_d[9];
    if (plain_coding_select_in)
    begin
      line_d = nrz_bit;
    end
    else
    begin
      line_d = line_q ^ nrz_bit;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      shift_q <= 10'h000;
      line_q <= 1'b0;
    end
    else
    begin
      shift_q <= shift_d;
      line_q <= line_d;
    end
  end

  assign serial_out = line_q;

endmodule : txis_shifter

// [txis_asserts.sv]
/*
  Checker of the transmit output stage, bound onto txis_top.
  Assumes one clock domain and the mode and symbol codes of the map header.
*/
`timescale 1ns/10ps
`include "txis_map.svh"

module txis_asserts
  import txis_pkg::*;
#(
  parameter int THRESH_W = 8
)
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire txis_byte_t req_second_in,
  input wire logic [5:0] path_config_reg_in,
  input wire logic [7:0] transmit_state_reg_in,
  input wire logic [7:0] injection_ctl_reg_in,
  input wire logic [7:0] mode_reg_in,
  input wire logic [4:0] injection_symbol_first_in,
  input wire logic [4:0] injection_symbol_second_in,
  input wire txis_code_pair_t filtered_pair_in,
  input wire txis_byte_t indicate_first_out,
  input wire txis_byte_t tx_path_out,
  input wire logic byte_strobe_out,
  input wire txis_code_pair_t tx_pair_out,
  input wire logic injecting_out,
  input wire logic pmd_tx_enable_out,
  input wire logic serial_out
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  logic [2:0] tm;
  logic [1:0] ic;
  logic st_none;
  assign tm = transmit_state_reg_in[2:0];
  assign ic = injection_ctl_reg_in[1:0];
  assign st_none = byte_strobe_out && ic == `TXIS_IC_NONE;

  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  a_strobe_gap: assert property (byte_strobe_out |=> !byte_strobe_out [*8])
    else $error("strobe repeated inside a byte");
  a_strobe_period: assert property (byte_strobe_out |-> ##10 byte_strobe_out)
    else $error("strobe period not ten cycles");
  a_off_disable: assert property (tm == `TXIS_TM_OFF |=> !pmd_tx_enable_out)
    else $error("transmitter enabled in off mode");
  a_on_enable: assert property (!rst_in && tm != `TXIS_TM_OFF |=> pmd_tx_enable_out)
    else $error("transmitter disabled outside off mode");
  a_link_invalid: assert property (path_config_reg_in[5:4] == `TXIS_BUS_LINK_INVALID
    |=> tx_path_out == `TXIS_LINK_INVALID)
    else $error("link invalid pattern wrong");
  a_ind_select: assert property (path_config_reg_in[1:0] == `TXIS_BUS_SECOND_REQ
    |=> indicate_first_out == $past(req_second_in))
    else $error("first indicate not second request");
  a_active_pass: assert property (st_none && tm == `TXIS_TM_ACTIVE
    |=> tx_pair_out == $past(filtered_pair_in) && !injecting_out)
    else $error("active stream altered");
  a_idle_pair: assert property (st_none && tm == `TXIS_TM_IDLE
    |=> tx_pair_out == {`TXIS_SYM_IDLE, `TXIS_SYM_IDLE})
    else $error("idle pair wrong");
  a_halt_pair: assert property (st_none && tm == `TXIS_TM_HALT
    |=> tx_pair_out == {`TXIS_SYM_HALT, `TXIS_SYM_HALT})
    else $error("halt pair wrong");
  a_quiet_pair: assert property (st_none && tm inside {3'h1, 3'h4, 3'h5, 3'h7}
    |=> tx_pair_out == {`TXIS_SYM_QUIET, `TXIS_SYM_QUIET})
    else $error("quiet pair wrong");
  a_master_alt: assert property (st_none && tm == `TXIS_TM_MASTER ##10
    st_none && tm == `TXIS_TM_MASTER |=> tx_pair_out != $past(tx_pair_out, 10))
    else $error("master pairs not alternating");
  a_cont_inject: assert property (byte_strobe_out && ic == `TXIS_IC_CONT
    |=> injecting_out && tx_pair_out == {$past(injection_symbol_first_in),
    $past(injection_symbol_second_in)})
    else $error("continuous injection wrong");
  a_plain_bit: assert property (byte_strobe_out && mode_reg_in[`TXIS_MODE_PLAIN_BIT]
    |=> serial_out == tx_pair_out.first[4])
    else $error("plain first bit wrong");

  c_cont: cover property (byte_strobe_out && ic == `TXIS_IC_CONT);
  c_master: cover property (st_none && tm == `TXIS_TM_MASTER);
  c_oneshot: cover property (injecting_out && ic == `TXIS_IC_ONESHOT);
endmodule : txis_asserts

bind txis_top txis_asserts #(.THRESH_W(THRESH_W)) u_asserts (
  .ref_clk_in(ref_clk_in),
  .rst_in(rst_in),
  .req_second_in(req_second_in),
  .path_config_reg_in(path_config_reg_in),
  .transmit_state_reg_in(transmit_state_reg_in),
  .injection_ctl_reg_in(injection_ctl_reg_in),
  .mode_reg_in(mode_reg_in),
  .injection_symbol_first_in(injection_symbol_first_in),
  .injection_symbol_second_in(injection_symbol_second_in),
  .filtered_pair_in(filtered_pair_in),
  .indicate_first_out(indicate_first_out),
  .tx_path_out(tx_path_out),
  .byte_strobe_out(byte_strobe_out),
  .tx_pair_out(tx_pair_out),
  .injecting_out(injecting_out),
  .pmd_tx_enable_out(pmd_tx_enable_out),
  .serial_out(serial_out)
);

// [txis_pmd_model.sv]
/*
  Line receiver model: decodes the serial line back into symbol pairs.
  Assumes the byte strobe frames each ten-bit pair on the one clock.
*/
`timescale 1ns/10ps

module txis_pmd_model
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic serial_in,
  input wire logic strobe_in,
  input wire logic plain_in,
  output logic [9:0] rx_pair_out
);
  logic prev_q;
  logic [8:0] sh_q;
  logic bit_v;
  assign bit_v = plain_in ? serial_in : serial_in ^ prev_q;
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      prev_q <= 1'b0;
      sh_q <= 9'h000;
      rx_pair_out <= 10'h000;
    end
    else
    begin
      prev_q <= serial_in;
      sh_q <= {sh_q[7:0], bit_v};
      if (strobe_in)
        rx_pair_out <= {sh_q, bit_v};
    end
  end
endmodule : txis_pmd_model

// [txis_top_tb.sv]
/*
  Self-checking bench of the transmit output stage.
  Assumes the checker is bound and the line model decodes serial_out.
*/
`timescale 1ns/10ps
`include "txis_map.svh"

module txis_top_tb
  import txis_pkg::*;
;
  logic ref_clk_in, rst_in;
  txis_byte_t rq1, rq2, rcv, ind1, ind2, txp;
  txis_byte_t ind1s, ind2s, txps;
  logic [5:0] cfg;
  logic [7:0] tsr, icr, mode, thr;
  logic [4:0] sa, sb;
  txis_code_pair_t fp, pair;
  logic strobe, inj, pmd_en, ser;
  logic [9:0] rx_pair;
  int errors, tests_run, cyc;

  txis_top DUT (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .req_first_in(rq1),
    .req_second_in(rq2), .receive_bus_in(rcv), .path_config_reg_in(cfg),
    .transmit_state_reg_in(tsr), .injection_ctl_reg_in(icr), .mode_reg_in(mode),
    .injection_threshold_in(thr), .injection_symbol_first_in(sa),
    .injection_symbol_second_in(sb), .filtered_pair_in(fp), .indicate_first_out(ind1),
    .indicate_second_out(ind2), .tx_path_out(txp), .byte_strobe_out(strobe),
    .tx_pair_out(pair), .injecting_out(inj), .pmd_tx_enable_out(pmd_en), .serial_out(ser));
  txis_top #(.SINGLE_PORT(1'b1)) DUT_sp (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .req_first_in(rq1), .req_second_in(rq2), .receive_bus_in(rcv), .path_config_reg_in(cfg),
    .transmit_state_reg_in(tsr), .injection_ctl_reg_in(icr), .mode_reg_in(mode),
    .injection_threshold_in(thr), .injection_symbol_first_in(sa),
    .injection_symbol_second_in(sb), .filtered_pair_in(fp), .indicate_first_out(ind1s),
    .indicate_second_out(ind2s), .tx_path_out(txps), .byte_strobe_out(),
    .tx_pair_out(), .injecting_out(), .pmd_tx_enable_out(), .serial_out());
  txis_pmd_model u_pmd (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .serial_in(ser),
    .strobe_in(strobe), .plain_in(mode[6]), .rx_pair_out(rx_pair));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  initial
  begin
    ref_clk_in = 1'b0;
    forever #20 ref_clk_in = ~ref_clk_in;
  end

  task automatic results;
    if (errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results

  always @(posedge ref_clk_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, cyc, 0);
      results;
    end
  end

  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one byte period: feed a pair, return the pair chosen at the strobe
  task automatic step(input logic [9:0] f, output logic [9:0] p, output logic i);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    fp <= f;
    @(negedge ref_clk_in);
    while (strobe !== 1'b1 && n < 20)
    begin
      @(negedge ref_clk_in);
      n++;
    end
    if (n >= 20)
    begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, strobe, 1'b1);
    end
    @(negedge ref_clk_in);
    p = pair;
    i = inj;
  endtask : step

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_switch;
    logic [9:0] bus [4];
    bus = '{10'h2A5, 10'h15A, 10'h0F3, 10'h13A};
    @(posedge ref_clk_in);
    rq1 <= 10'h2A5;
    rq2 <= 10'h15A;
    rcv <= 10'h0F3;
    for (int s = 0; s < 4; s++)
    begin
      @(posedge ref_clk_in);
      cfg <= {2'(s), 2'(s + 1), 2'(s + 2)};
      repeat (2) @(posedge ref_clk_in);
      @(negedge ref_clk_in);
      chk(txp, bus[s]);
      chk(ind2, bus[(s + 1) % 4]);
      chk(ind1, bus[(s + 2) % 4]);
      chk(txps, s == 0 ? 10'h13A : bus[s]);
      chk(ind1s, (s + 2) % 4 == 0 ? 10'h13A : bus[(s + 2) % 4]);
      chk(ind2s, 10'h000);
    end
  endtask : t_switch

  task automatic t_modes;
    logic [9:0] p, q, e;
    logic i;
    for (int m = 0; m < 8; m++)
    begin
      @(posedge ref_clk_in);
      tsr <= 8'(m);
      step(10'h2B5, p, i);
      step(10'h2B5, p, i);
      step(10'h2B5, q, i);
      e = m == 0 ? 10'h2B5 : m == 2 ? {`TXIS_SYM_IDLE, `TXIS_SYM_IDLE} :
        m == 6 ? {`TXIS_SYM_HALT, `TXIS_SYM_HALT} : 10'h000;
      if (m == 3)
        chk(p ^ q, {`TXIS_SYM_HALT, `TXIS_SYM_HALT});
      else
        chk(q, e);
      chk({9'h000, pmd_en}, {9'h000, m != 1});
    end
  endtask : t_modes

  task automatic t_inject;
    logic [9:0] p;
    logic i;
    int hits;
    int tv [3] = '{0, 3, 255};
    @(posedge ref_clk_in);
    sa <= 5'h0D;
    sb <= 5'h16;
    tsr <= 8'h02;
    icr <= 8'h03;
    step(10'h2B5, p, i);
    step(10'h2B5, p, i);
    chk(p, 10'h1B6);
    for (int k = 0; k < 3; k++)
    begin
      @(posedge ref_clk_in);
      icr <= 8'h02;
      thr <= 8'(tv[k]);
      step(10'h2B5, p, i);
      hits = 0;
      for (int b = 0; b < (tv[k] == 0 ? 4 : 4 * tv[k]); b++)
      begin
        step(10'h2B5, p, i);
        hits += int'(i === 1'b1);
      end
      chk(10'(hits), 10'h004);
    end
  endtask : t_inject

  task automatic t_oneshot;
    logic [9:0] p;
    logic i;
    for (int n = 0; n < 3; n += 2)
    begin
      @(posedge ref_clk_in);
      tsr <= 8'h00;
      icr <= 8'h01;
      thr <= 8'(n);
      step(10'h2B5, p, i);
      step(10'h2B5, p, i);
      step({`TXIS_SYM_J, `TXIS_SYM_K}, p, i);
      chk(p, n == 0 ? 10'h1B6 : {`TXIS_SYM_J, `TXIS_SYM_K});
      for (int b = 1; b < 5; b++)
      begin
        step(10'h2B5, p, i);
        chk(p, b == n ? 10'h1B6 : 10'h2B5);
      end
    end
    @(posedge ref_clk_in);
    icr <= 8'h00;
  endtask : t_oneshot

  task automatic t_serial;
    logic [9:0] p, q;
    logic i;
    for (int m = 0; m < 2; m++)
    begin
      @(posedge ref_clk_in);
      mode <= 8'(m) << `TXIS_MODE_PLAIN_BIT;
      step(10'h3C1, p, i);
      step(10'h2B5, p, i);
      step(10'h15A, q, i);
      chk(p, 10'h2B5);
      chk(rx_pair, 10'h2B5);
    end
  endtask : t_serial

  initial
  begin
    errors = 0;
    tests_run = 0;
    cyc = 0;
    rst_in = 1'b1;
    rq1 = 10'h000;
    rq2 = 10'h000;
    rcv = 10'h000;
    cfg = 6'h00;
    tsr = 8'h00;
    icr = 8'h00;
    mode = 8'h00;
    thr = 8'h00;
    sa = 5'h00;
    sb = 5'h00;
    fp = 10'h000;
    repeat (10) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    t_switch;
    t_modes;
    t_inject;
    t_oneshot;
    t_serial;
    results;
  end
endmodule : txis_top_tb
